// *** src/slcd_pkg.sv ***
// constants, types and level coding shared by the segment lcd controller files
package slcd_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] CLKGATE_IDX = 16'hFF4A;
    localparam logic [15:0] MODE_IDX = 16'hFFB0;
    localparam logic [15:0] CTRL_IDX = 16'hFFB2;
    localparam logic [15:0] DDM_FIRST_IDX = 16'hFA59;
    localparam logic [15:0] DDM_LAST_IDX = 16'hFA6C;
    localparam int ADDR_W = 18;
    localparam logic [17:0] CLKGATE_ADDR = {CLKGATE_IDX, 2'b00};
    localparam logic [17:0] MODE_ADDR = {MODE_IDX, 2'b00};
    localparam logic [17:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    // panel geometry
    localparam int NUM_SEG = 20;
    localparam int NUM_COM = 4;
    localparam int NUM_SHARED = 15;
    localparam int FIRST_SHARED = 5;
    localparam int DDM_W = 4;
    // field positions
    localparam int DISP_ON_BIT = 7;
    localparam int CLK_SEL_LSB = 4;
    localparam int PIN_CNT_LSB = 4;
    localparam int SUPPLY_BIT = 0;
    localparam int CLK_SUPPLY_BIT = 1;
    // writable masks and reset values
    localparam logic [7:0] MODE_MASK = 8'hF0;
    localparam logic [7:0] CTRL_MASK = 8'hF1;
    localparam logic [7:0] CLKGATE_MASK = 8'h02;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CLKGATE_RST = 8'h00;
    localparam logic [3:0] DDM_RST = 4'h0;
    // divider exponent of the fastest panel clock (code 011)
    localparam int DIV_LOG2_FAST = 14;
    // drive levels: vss, 1/3, 2/3, full lcd voltage
    typedef logic [1:0] slcd_level_t;
    localparam slcd_level_t LVL_VSS = 2'h0;
    localparam slcd_level_t LVL_VLC2 = 2'h1;
    localparam slcd_level_t LVL_VLC1 = 2'h2;
    localparam slcd_level_t LVL_VLC0 = 2'h3;

    // level of a line for its select state, kind and current polarity
    function automatic slcd_level_t slcd_level(input logic sel, input logic is_com,
                                               input logic pol);
        slcd_level_t lv;
        if (is_com)
            lv = sel ? (pol ? LVL_VSS : LVL_VLC0) : (pol ? LVL_VLC1 : LVL_VLC2);
        else
            lv = sel ? (pol ? LVL_VLC0 : LVL_VSS) : (pol ? LVL_VLC2 : LVL_VLC1);
        return lv;
    endfunction
endpackage

// *** src/slcd_scan_if.sv ***
// timing link between the register side and the phase scanner
`timescale 1ns/1ps
`default_nettype none
interface slcd_scan_if;
    logic run; // panel clock supplied
    logic [2:0] clk_sel; // panel clock select code
    logic [1:0] phase; // current common phase
    logic polarity; // current drive polarity
    logic step; // one-cycle pulse per panel clock period
    modport scanner (input run, input clk_sel, output phase, output polarity, output step);
    modport ctrl (output run, output clk_sel, input phase, input polarity, input step);
endinterface
`default_nettype wire

// *** src/slcd_scan.sv ***
// panel clock divider and common phase / polarity sequencer
`timescale 1ns/1ps
`default_nettype none
module slcd_scan
    import slcd_pkg::*;
#(
    parameter int DIV_FAST = DIV_LOG2_FAST
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    slcd_scan_if.scanner sif
);
    localparam int CNT_W = DIV_FAST + 3;
    logic [CNT_W-1:0] div_reg; // free divider of the main clock
    logic [CNT_W-1:0] mask; // low bits that must be all ones for a step
    logic [1:0] phase_reg; // common phase counter
    logic pol_reg; // ac drive polarity
    logic tick;

    ////////////////////////////////////////////////////////////////////////
    // the slow codes shift the mask up; prohibited codes fold onto the low two bits
    always_comb
    begin
        mask = ~({CNT_W{1'b1}} << (DIV_FAST + 3 - int'(sif.clk_sel[1:0])));
        tick = sif.run && ((div_reg & mask) == mask);
    end

    // divider holds at zero while the clock supply is gated off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_reg <= '0;
        else if (ce)
            div_reg <= sif.run ? div_reg + 1'b1 : '0;
    end

    // one phase per panel clock period, fixed order 0..3
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_reg <= 2'h0;
        else if (ce && tick)
            phase_reg <= phase_reg + 2'h1;
    end

    // polarity flips when a full frame of four phases ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pol_reg <= 1'b0;
        else if (ce && tick && phase_reg == 2'h3)
            pol_reg <= ~pol_reg;
    end

    assign sif.phase = phase_reg;
    assign sif.polarity = pol_reg;
    assign sif.step = ce && tick;

    ////////////////////////////////////////////////////////////////////////
    a_phase_order: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && tick) |=> phase_reg == $past(phase_reg) + 2'h1)
        else $error("common phase did not advance in order");
    a_pol_frame: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && tick && phase_reg == 2'h3) |=> pol_reg != $past(pol_reg))
        else $error("polarity did not flip at frame end");
endmodule // slcd_scan
`default_nettype wire

// *** src/slcd_ctrl.sv ***
// segment lcd controller: apb registers, display memory, line levels, shared pins
`timescale 1ns/1ps
`default_nettype none
module slcd_ctrl
    import slcd_pkg::*;
#(
    parameter int DIV_FAST = DIV_LOG2_FAST // exponent of fastest panel clock divider
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [slcd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [slcd_pkg::NUM_SHARED-1:0] port_latch,
    input wire logic [slcd_pkg::NUM_SHARED-1:0] port_mode_in,
    input wire logic [slcd_pkg::NUM_SHARED-1:0] pin_in,
    output logic [slcd_pkg::NUM_SHARED-1:0] pin_out,
    output logic [slcd_pkg::NUM_SHARED-1:0] pin_oe_n,
    output logic [slcd_pkg::NUM_SHARED-1:0] port_rd_data,
    output logic [slcd_pkg::NUM_SEG-1:0] seg_drive_en,
    output slcd_pkg::slcd_level_t [slcd_pkg::NUM_SEG-1:0] seg_level,
    output slcd_pkg::slcd_level_t [slcd_pkg::NUM_COM-1:0] com_level,
    output logic drive_supply_enable,
    output logic panel_clock_run
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0] mode_reg; // display on and clock select
    logic [7:0] ctrl_reg; // segment pin count and drive supply
    logic [7:0] clkgate_reg; // write-only clock supply gate
    logic [DDM_W-1:0] ddm_reg [NUM_SEG]; // display data, low nibble only
    logic [31:0] prdata_reg; // read data captured in setup
    logic slverr_reg; // unmapped address flag for the transfer
    logic captured_reg; // read data ready for the access phase
    logic [31:0] rd_next; // read mux result
    logic hit_next; // address maps to something
    logic wr_en; // write commits at this edge

    logic [NUM_SHARED-1:0] pin_s1_reg; // first synchroniser stage
    logic [NUM_SHARED-1:0] pin_s2_reg; // second synchroniser stage
    logic [NUM_SHARED-1:0] shared_seg; // shared pin is in segment function
    logic [NUM_SHARED-1:0] pin_out_reg;
    logic [NUM_SHARED-1:0] pin_oe_n_reg;
    logic [NUM_SHARED-1:0] port_rd_reg;
    logic [NUM_SEG-1:0] seg_en_reg;
    slcd_level_t [NUM_SEG-1:0] seg_level_reg;
    slcd_level_t [NUM_COM-1:0] com_level_reg;
    logic display_on;
    logic [3:0] pin_count;

    // the scanner owns phase and polarity; this side feeds run and clock code
    slcd_scan_if sif ();

    ////////////////////////////////////////////////////////////////////////
    // address decode helpers, shared by the read mux and the write path
    function automatic logic addr_is_ddm(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] >= DDM_FIRST_IDX)
            && (a[ADDR_W-1:2] <= DDM_LAST_IDX);
    endfunction

    function automatic logic [4:0] ddm_index(input logic [ADDR_W-1:0] a);
        logic [15:0] d;
        d = a[ADDR_W-1:2] - DDM_FIRST_IDX;
        return d[4:0];
    endfunction

    // field views of the two control registers
    assign display_on = mode_reg[DISP_ON_BIT];
    assign pin_count = ctrl_reg[PIN_CNT_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////
    // apb slave: read data is captured in the setup cycle so the access
    // phase can answer at once from flip-flops; ce low stalls via pready
    assign wr_en = ce && psel && penable && pready && pwrite;
    assign pready = ce && penable && captured_reg;
    assign prdata = prdata_reg;
    assign pslverr = pready && slverr_reg;

    // read mux; write-only gate and absent bits read as zero
    // a write still runs the mux; only its error flag is kept
    always_comb
    begin
        rd_next = 32'h0000_0000;
        hit_next = 1'b1;
        if (addr_is_ddm(paddr))
            rd_next = {28'h000_0000, ddm_reg[ddm_index(paddr)]};
        else if (paddr == MODE_ADDR)
            rd_next = {24'h00_0000, mode_reg};
        else if (paddr == CTRL_ADDR)
            rd_next = {24'h00_0000, ctrl_reg};
        else if (paddr == CLKGATE_ADDR)
            rd_next = 32'h0000_0000;
        else
            hit_next = 1'b0;
    end

    // capture once per transfer, drop after the completing edge
    // a write captures too, so its error flag is ready for the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
            captured_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (psel && !pready && !captured_reg)
            begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
                slverr_reg <= ~hit_next;
                captured_reg <= 1'b1;
            end
            else if (pready)
                captured_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers; reserved bits never store
    // prohibited codes store as written; the scanner folds them onto legal ones
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_reg <= MODE_RST;
        else if (wr_en && paddr == MODE_ADDR)
            mode_reg <= pwdata[7:0] & MODE_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= CTRL_RST;
        else if (wr_en && paddr == CTRL_ADDR)
            ctrl_reg <= pwdata[7:0] & CTRL_MASK;
    end

    // clock supply gate: only bit 1 has meaning
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clkgate_reg <= CLKGATE_RST;
        else if (wr_en && paddr == CLKGATE_ADDR)
            clkgate_reg <= pwdata[7:0] & CLKGATE_MASK;
    end

    // display data memory; every byte is plain ram whether shown or not
    // bytes of lines left as ports are still scanned, but no driver is on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_SEG; i++)
                ddm_reg[i] <= DDM_RST;
        end
        else if (wr_en && addr_is_ddm(paddr))
            ddm_reg[ddm_index(paddr)] <= pwdata[DDM_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // phase scanner; runs with no software step per frame
    // prohibited clock codes reach the scanner unchanged
    assign sif.run = clkgate_reg[CLK_SUPPLY_BIT];
    assign sif.clk_sel = mode_reg[CLK_SEL_LSB +: 3];

    slcd_scan #(
        .DIV_FAST(DIV_FAST)
    ) u_scan (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .sif(sif.scanner)
    );

    ////////////////////////////////////////////////////////////////////////
    // segment line levels: bit of the current phase, deselected when off
    generate
        for (genvar s = 0; s < NUM_SEG; s++)
        begin : g_seg
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    seg_level_reg[s] <= LVL_VSS;
                else if (ce)
                    seg_level_reg[s] <= slcd_level(display_on && ddm_reg[s][sif.phase],
                        1'b0, sif.polarity);
            end
        end
    endgenerate

    // common line levels: exactly one common selected per phase
    generate
        for (genvar c = 0; c < NUM_COM; c++)
        begin : g_com
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    com_level_reg[c] <= LVL_VSS;
                else if (ce)
                    com_level_reg[c] <= slcd_level(sif.phase == 2'(c), 1'b1,
                        sif.polarity);
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // shared pins: segment function claimed two pins per count step
    // counts 9 to 15 are prohibited and simply claim every shared pin
    generate
        for (genvar p = 0; p < NUM_SHARED; p++)
        begin : g_shared
            assign shared_seg[p] = (5'(p) < {pin_count, 1'b0});
        end
    endgenerate

    // pin synchroniser; only the second stage is read by logic
    // pins move at any time, so only the second stage reads the first stage's value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end
        else if (ce)
        begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // port buffer is cut off from a pin in segment function
    // the latch keeps its value; only its path to the pin is cut
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_reg <= '0;
            pin_oe_n_reg <= '1;
        end
        else if (ce)
        begin
            pin_out_reg <= port_latch & ~shared_seg;
            pin_oe_n_reg <= port_mode_in | shared_seg;
        end
    end

    // port read masks segment pins to zero
    // the mask follows the control register one edge later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_rd_reg <= '0;
        else if (ce)
            port_rd_reg <= pin_s2_reg & ~shared_seg;
    end

    // segment driver enables: five dedicated lines, then the shared ones
    // dedicated lines have no port function, so they are on from the first ce edge after reset, which clears them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seg_en_reg <= '0;
        else if (ce)
            seg_en_reg <= {shared_seg, {FIRST_SHARED{1'b1}}};
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // the supply bit only goes out on drive_supply_enable; levels drive regardless
    assign pin_out = pin_out_reg;
    assign pin_oe_n = pin_oe_n_reg;
    assign port_rd_data = port_rd_reg;
    assign seg_drive_en = seg_en_reg;
    assign seg_level = seg_level_reg;
    assign com_level = com_level_reg;
    assign drive_supply_enable = ctrl_reg[SUPPLY_BIT];
    assign panel_clock_run = sif.run;

    ////////////////////////////////////////////////////////////////////////
    // checks; all but the read and freeze checks look one edge after their cause, where the level has settled
    a_gate_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && paddr == CLKGATE_ADDR) |-> prdata == 32'h0000_0000)
        else $error("clock gate register did not read zero");

    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == MODE_ADDR) |=> mode_reg == ($past(pwdata[7:0]) & 8'hF0))
        else $error("mode register write not stored");

    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CTRL_ADDR) |=> ctrl_reg == ($past(pwdata[7:0]) & 8'hF1))
        else $error("control register write not stored");

    a_ddm_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && addr_is_ddm(paddr)) |=>
            ddm_reg[$past(ddm_index(paddr))] == $past(pwdata[DDM_W-1:0]))
        else $error("display memory write not stored");

    a_ddm_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && addr_is_ddm(paddr)) |-> prdata[31:4] == 28'h000_0000)
        else $error("display memory upper bits not zero");

    a_off_nonselect: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !display_on) |=> seg_level_reg[0] == slcd_level(1'b0, 1'b0,
            $past(sif.polarity)))
        else $error("segment selected while display off");

    a_seg_bit_phase: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && display_on) |=> seg_level_reg[NUM_SEG-1] == slcd_level(
            $past(ddm_reg[NUM_SEG-1][sif.phase]), 1'b0, $past(sif.polarity)))
        else $error("segment level does not follow phase bit");

    a_com_select: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> com_level_reg[$past(sif.phase)] == slcd_level(1'b1, 1'b1,
            $past(sif.polarity)))
        else $error("current common not selected");

    a_com_one_sel: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> com_level_reg[2'($past(sif.phase) + 2'h1)] == slcd_level(1'b0, 1'b1,
            $past(sif.polarity)))
        else $error("more than one common selected");

    a_dedicated_segs: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> seg_en_reg[FIRST_SHARED-1:0] == 5'h1F)
        else $error("dedicated segment line not enabled");

    a_seg_pin_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && shared_seg[0]) |=> pin_oe_n_reg[0] && !pin_out_reg[0])
        else $error("port drives a segment pin");

    a_seg_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && shared_seg[NUM_SHARED-1]) |=> !port_rd_reg[NUM_SHARED-1])
        else $error("segment pin read as nonzero");

    a_gate_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        (!sif.run && $past(!sif.run)) |-> $stable(sif.phase) && $stable(sif.polarity))
        else $error("scanner moved with clock supply off");
endmodule // slcd_ctrl
`default_nettype wire

// *** tb/slcd_panel.sv ***
// glass panel model: turns common and segment levels into lit pixels
`timescale 1ns/1ps
`default_nettype none
module slcd_panel
    import slcd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire slcd_pkg::slcd_level_t [slcd_pkg::NUM_SEG-1:0] seg_level,
    input wire slcd_pkg::slcd_level_t [slcd_pkg::NUM_COM-1:0] com_level,
    output logic [slcd_pkg::NUM_SEG*slcd_pkg::NUM_COM-1:0] lit,
    output var int order_err,
    output var int phase_len,
    output logic [1:0] seen_pol
);
    int last_com; // common selected in the previous cycle
    int run_len; // cycles the current common has stayed selected
    ////////////////////////////////////////////////////////////////////////
    // a pixel lights only at a full swing; a third-level swing stays dark
    always_ff @(posedge pclk or negedge presetn)
    begin : decode
        int cur;
        cur = -1;
        if (!presetn)
        begin
            lit <= '0;
            order_err <= 0;
            phase_len <= 0;
            seen_pol <= 2'b00;
            last_com <= -1;
            run_len <= 0;
        end
        else
        begin
            for (int c = 0; c < NUM_COM; c++)
                if (com_level[c] == LVL_VSS || com_level[c] == LVL_VLC0)
                    cur = c;
            // common 0 selected at either end of the swing marks the polarity
            if (com_level[0] == LVL_VLC0)
                seen_pol[0] <= 1'b1;
            if (com_level[0] == LVL_VSS)
                seen_pol[1] <= 1'b1;
            if (cur >= 0)
            begin
                for (int s = 0; s < NUM_SEG; s++)
                    lit[s*NUM_COM+cur] <= (seg_level[s] == LVL_VSS && com_level[cur] == LVL_VLC0)
                        || (seg_level[s] == LVL_VLC0 && com_level[cur] == LVL_VSS);
                if (cur != last_com)
                begin
                    // commons must follow 0,1,2,3 without skipping
                    if (last_com >= 0 && cur != (last_com + 1) % NUM_COM)
                        order_err <= order_err + 1;
                    phase_len <= run_len;
                    run_len <= 1;
                    last_com <= cur;
                end
                else
                    run_len <= run_len + 1;
            end
        end
    end
endmodule // slcd_panel
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the segment lcd controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import slcd_pkg::*;
    localparam int DIVF = 2; // short divider keeps a frame within a few hundred cycles
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, supply, run;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [NUM_SHARED-1:0] latch, pmode, pin_in, pin_out, pin_oe_n, port_rd;
    logic [NUM_SEG-1:0] seg_en;
    slcd_level_t [NUM_SEG-1:0] seg_level;
    slcd_level_t [NUM_COM-1:0] com_level, com_hold;
    logic [NUM_SEG*NUM_COM-1:0] lit, exp_lit;
    int order_err, phase_len, err_count, num_checks;
    logic [1:0] seen_pol;
    ////////////////////////////////////////////////////////////////////////
    slcd_ctrl #(.DIV_FAST(DIVF)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_latch(latch),
        .port_mode_in(pmode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .port_rd_data(port_rd), .seg_drive_en(seg_en), .seg_level(seg_level),
        .com_level(com_level), .drive_supply_enable(supply), .panel_clock_run(run));
    slcd_panel panel (.pclk(pclk), .presetn(presetn), .seg_level(seg_level),
        .com_level(com_level), .lit(lit), .order_err(order_err), .phase_len(phase_len),
        .seen_pol(seen_pol));
    ////////////////////////////////////////////////////////////////////////
    // compare and count; a mismatch is reported at once
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
        @(posedge pclk); // let the register settle before anyone looks
    endtask
    task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(name, {24'h0, x}, r);
        chk({name, " err"}, 32'h0, {31'h0, e});
    endtask
    // byte address of display memory byte s
    function automatic logic [ADDR_W-1:0] ma(input int s);
        return {DDM_FIRST_IDX + 16'(s), 2'b00};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // values straight after reset
    task automatic t_reset();
        rdchk("mode", MODE_ADDR, 8'h00);
        rdchk("ctrl", CTRL_ADDR, 8'h00);
        chk("seg_en", 32'h1F, {12'h0, seg_en});
        chk("run", 32'h0, {31'h0, run});
    endtask
    // register masks, supply enable, write-only gate and an unmapped access
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        wr(MODE_ADDR, 8'hBF);
        rdchk("mode", MODE_ADDR, 8'hB0);
        wr(CTRL_ADDR, 8'h8F);
        rdchk("ctrl", CTRL_ADDR, 8'h81);
        chk("supply", 32'h1, {31'h0, supply});
        wr(CTRL_ADDR, 8'h00);
        chk("supply", 32'h0, {31'h0, supply});
        wr(MODE_ADDR, 8'h00);
        wr(CLKGATE_ADDR, 8'hFF);
        rdchk("gate", CLKGATE_ADDR, 8'h00);
        chk("run", 32'h1, {31'h0, run});
        apb(1'b1, 18'h00010, 32'hFF, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
    endtask
    // display memory: plain ram in low nibble, upper nibble absent
    task automatic t_mem();
        wr(ma(19), 8'hFF);
        rdchk("mem19", ma(19), 8'h0F);
        for (int s = 0; s < NUM_SEG; s++)
            wr(ma(s), 8'(s & 15));
        for (int s = 0; s < NUM_SEG; s++)
            rdchk("mem", ma(s), 8'(s & 15));
    endtask
    // shared pins switch to segments two at a time from line 5
    task automatic t_pins(input logic [3:0] code, input logic [14:0] segs);
        wr(CTRL_ADDR, {code, 4'h1});
        repeat (5) @(posedge pclk);
        chk("pin_out", {17'h0, 15'h7FFF & ~segs}, {17'h0, pin_out});
        chk("pin_oe_n", {17'h0, segs}, {17'h0, pin_oe_n});
        chk("port_rd", {17'h0, 15'h7FFF & ~segs}, {17'h0, port_rd});
        chk("seg_en", {12'h0, segs, 5'h1F}, {12'h0, seg_en});
    endtask
    // scanning at clock codes 3 down to 0: phase length, order, data bits, polarity
    task automatic t_scan(input logic [2:0] code);
        int len;
        len = 1 << (DIVF + 3 - code);
        wr(MODE_ADDR, {1'b1, code, 4'h0});
        repeat (16 * len) @(posedge pclk);
        chk("phase_len", len, phase_len);
        chk("lit", exp_lit[31:0], lit[31:0]);
        chk("lit_hi", exp_lit[79:48], lit[79:48]);
        chk("order", 0, order_err);
        chk("polarity", 2'b11, seen_pol);
    endtask
    // display off shows nothing; clock gate off freezes the scan
    task automatic t_stop();
        wr(MODE_ADDR, 8'h30);
        repeat (80) @(posedge pclk);
        chk("lit_off", 32'h0, lit[31:0] | lit[79:48]);
        ce <= 1'b0;
        @(posedge pclk);
        com_hold = com_level;
        repeat (40) @(posedge pclk);
        chk("ce_hold", {24'h0, com_hold}, {24'h0, com_level});
        ce <= 1'b1;
        wr(CLKGATE_ADDR, 8'h00);
        repeat (3) @(posedge pclk);
        com_hold = com_level;
        repeat (64) @(posedge pclk);
        chk("frozen", {24'h0, com_hold}, {24'h0, com_level});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // clock at 50 ns
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // hang guard, well beyond the 1400 or so cycles of the tests
    initial
    begin
        repeat (40000) @(posedge pclk);
        err_count++;
        conclude();
    end
    // main sequence, registers and memory first, then pins, then clock
    initial
    begin
        err_count = 0;
        num_checks = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        latch = 15'h7FFF;
        pmode = 15'h0000; // ports set as outputs so the latch would win if unguarded
        pin_in = 15'h7FFF;
        for (int s = 0; s < NUM_SEG; s++)
            for (int k = 0; k < NUM_COM; k++)
                exp_lit[s*NUM_COM+k] = (s & 15) >> k & 1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_regs();
        t_mem();
        t_pins(4'h1, 15'h0003);
        t_pins(4'h8, 15'h7FFF);
        for (int c = 3; c >= 0; c--)
            t_scan(3'(c));
        t_stop();
        conclude();
    end
endmodule // testbench
`default_nettype wire
